// ===== dsad_pkg.sv
// Shared constants and types for the data space address decoder.
// Assumes a 24-bit byte address and an 8-bit data bus on the load/store side.
package dsad_pkg;
  // Region boundaries; the bases are shared, the ends are given per memory-size variant.
  localparam logic [23:0] IO_END = 24'h000fff;
  localparam logic [23:0] EE_BASE = 24'h001000;
  localparam logic [23:0] EE_END_2K = 24'h0017ff;
  localparam logic [23:0] EE_END_4K = 24'h001fff;
  localparam logic [23:0] SRAM_BASE = 24'h002000;
  localparam logic [23:0] SRAM_END_4K = 24'h002fff;
  localparam logic [23:0] SRAM_END_8K = 24'h003fff;
  localparam logic [23:0] SRAM_END_16K = 24'h005fff;
  localparam logic [23:0] SRAM_END_32K = 24'h009fff;
  localparam logic [23:0] EXT_BASE_32K = 24'h010000;
  localparam logic [23:0] ADDR_ONE = 24'h000001;
  // Reach of the short I/O and single-bit instructions.
  localparam logic [23:0] SHORT_IO_END = 24'h00003f;
  localparam logic [23:0] BIT_IO_END = 24'h00001f;
  // Static memory reach with only two ports given to the external bus.
  localparam logic [23:0] STATIC_2PORT_END = 24'h07ffff;
  // External address width limits and chip select size limit.
  localparam logic [4:0] EXT_BITS_MIN = 5'h08;
  localparam logic [4:0] EXT_BITS_MAX = 5'h18;
  localparam logic [4:0] CS_SIZE_MAX = 5'h10;
  localparam int CS_COUNT = 4;
  // Field positions of the flash pointer and the EEPROM address.
  localparam int FLASH_WORD_LSB = 1;
  localparam int FLASH_PAGE_LSB_SMALL = 8;
  localparam int FLASH_PAGE_LSB = 9;
  localparam logic [7:0] FLASH_WORD_MASK_SMALL = 8'h7f;
  localparam logic [10:0] FLASH_PAGE_MASK_SMALL = 11'h1ff;
  localparam int EE_PAGE_LSB = 5;
  localparam logic [6:0] EE_PAGE_MASK_2K = 7'h3f;
  // Last calibration entry copied out after reset.
  localparam logic [3:0] CAL_LOAD_LAST = 4'h3;

  typedef enum logic [2:0] {
    RGN_IO = 3'b000,
    RGN_EE = 3'b001,
    RGN_SRAM = 3'b010,
    RGN_EXT = 3'b011,
    RGN_HOLE = 3'b100
  } dsad_region_t;

  typedef enum logic [1:0] {
    CS_STATIC = 2'b00,
    CS_REDUCED = 2'b01,
    CS_SDRAM = 2'b10,
    CS_OFF = 2'b11
  } dsad_cs_type_t;

  typedef enum logic [2:0] {
    NVM_CAL_READ = 3'b000,
    NVM_CAL_WRITE = 3'b001,
    NVM_CAL_ERASE = 3'b010,
    NVM_SIG_WRITE = 3'b011,
    NVM_SIG_ERASE = 3'b100,
    NVM_CHIP_ERASE = 3'b101
  } dsad_nvm_op_t;

  typedef enum logic {
    FSM_IDLE = 1'b0,
    FSM_WAIT = 1'b1
  } dsad_fsm_t;
endpackage

// ===== dsad_cs_match.sv
// Window match for one external chip select.
// Assumes the base is aligned to the window size; low base bits are ignored.
`timescale 1ns/100ps
`default_nettype none
module dsad_cs_match (
  input wire logic [23:0] addr,
  input wire logic [23:0] base,
  input wire logic [4:0] size,
  input wire logic [1:0] kind,
  input wire logic three_port,
  output logic hit
);
  logic [4:0] sz;
  logic [23:0] low;
  logic kind_ok;

  // Window of 256 bytes shifted up by size, clamped at 16M.
  always_comb begin
    sz = (size > dsad_pkg::CS_SIZE_MAX) ? dsad_pkg::CS_SIZE_MAX : size;
    low = 24'hffffff >> (dsad_pkg::CS_SIZE_MAX - sz);
    // Dynamic memory needs three ports; two-port static memory stops at 512K.
    case (kind)
      dsad_pkg::CS_SDRAM: kind_ok = three_port;
      dsad_pkg::CS_OFF: kind_ok = 1'b0;
      default: kind_ok = three_port || (addr <= dsad_pkg::STATIC_2PORT_END);
    endcase
    hit = kind_ok && ((addr & ~low) == (base & ~low));
  end
endmodule
`default_nettype wire

// ===== dsad_cal_loader.sv
// Walks the calibration entries once after reset and strobes each out.
// Assumes receiving modules take the calibration byte themselves on the strobe.
`timescale 1ns/100ps
`default_nettype none
module dsad_cal_loader (
  input wire logic core_clk,
  input wire logic rst,
  output logic [3:0] cal_index,
  output logic cal_load,
  output logic cal_busy
);
  typedef struct packed {
    logic busy;
    logic [3:0] idx;
    logic load;
    logic [3:0] lidx;
  } dsad_cal_t;
  dsad_cal_t st;
  dsad_cal_t next_st;

  // One entry per cycle, from the first edge after reset is released.
  always_comb begin
    next_st = st;
    next_st.load = st.busy;
    next_st.lidx = st.idx;
    if (st.busy) begin
      if (st.idx == dsad_pkg::CAL_LOAD_LAST) begin
        next_st.busy = 1'b0;
      end else begin
        next_st.idx = st.idx + 4'h1;
      end
    end
  end

  // Busy comes up in reset so the bus is held off until the copy ends.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= '0;
      st.busy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign cal_index = st.lidx;
  assign cal_load = st.load;
  assign cal_busy = st.busy;
endmodule
`default_nettype wire

// ===== dsad_decoder.sv
// Data space address decoder: region select, chip selects, wait states,
// flash/EEPROM index split and non-volatile row protection.
// Assumes the bus master holds address and strobes while bus_stall is high.
`timescale 1ns/100ps
`default_nettype none
module dsad_decoder (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [23:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic short_io_op,
  input wire logic bit_access_op,
  input wire logic [7:0] tgt_rdata,
  input wire logic [1:0] sram_size,
  input wire logic eeprom_4k,
  input wire logic eeprom_mapped,
  input wire logic ee_space_req,
  input wire logic [11:0] ee_space_addr,
  input wire logic three_port,
  input wire logic [4:0] ext_addr_bits,
  input wire logic [1:0] ext_mux_mode,
  input wire logic [3:0][1:0] cs_type,
  input wire logic [3:0][23:0] cs_base,
  input wire logic [3:0][4:0] cs_size,
  input wire logic [3:0][3:0] cs_wait,
  input wire logic [1:0] sdram_cas,
  input wire logic [9:0] sdram_refresh_period,
  input wire logic [23:0] flash_ptr,
  input wire logic flash_small,
  input wire logic nvm_req,
  input wire logic [2:0] nvm_op,
  output logic sel_io,
  output logic sel_eeprom,
  output logic sel_sram,
  output logic sel_ext,
  output logic sel_hole,
  output logic [3:0] cs_sel,
  output logic [23:0] ext_addr,
  output logic [1:0] ext_phases,
  output logic bus_stall,
  output logic bus_done,
  output logic tgt_we,
  output logic [7:0] bus_rdata,
  output logic op_illegal,
  output logic [7:0] flash_word_index,
  output logic [10:0] flash_page_index,
  output logic [6:0] eeprom_page_index,
  output logic [4:0] eeprom_byte_index,
  output logic sdram_refresh_req,
  output logic nvm_accept,
  output logic nvm_reject,
  output logic sig_write_go,
  output logic sig_erase_go,
  output logic chip_erase_go,
  output logic [3:0] cal_index,
  output logic cal_load
);
  typedef struct packed {
    dsad_pkg::dsad_fsm_t fsm;
    logic [4:0] wait_cnt;
    logic wr_q;
    logic rd_q;
    logic [9:0] ref_cnt;
    logic sel_io;
    logic sel_eeprom;
    logic sel_sram;
    logic sel_ext;
    logic sel_hole;
    logic [3:0] cs_sel;
    logic [23:0] ext_addr;
    logic [1:0] ext_phases;
    logic bus_stall;
    logic bus_done;
    logic tgt_we;
    logic [7:0] bus_rdata;
    logic op_illegal;
    logic [7:0] flash_word_index;
    logic [10:0] flash_page_index;
    logic [6:0] eeprom_page_index;
    logic [4:0] eeprom_byte_index;
    logic sdram_refresh_req;
    logic nvm_accept;
    logic nvm_reject;
    logic sig_write_go;
    logic sig_erase_go;
    logic chip_erase_go;
  } dsad_state_t;

  dsad_state_t st;
  dsad_state_t next_st;
  logic [3:0] cs_hit;
  logic cal_busy;
  logic take;
  dsad_pkg::dsad_region_t rgn;
  logic [3:0] first_hit;
  logic [4:0] hit_wait;
  logic any_sdram;
  logic hole;
  logic [11:0] ee_split;
  logic [11:0] ee_sep;

  // Region of an address; the bases are fixed, the SRAM end and external start follow the variant.
  function automatic dsad_pkg::dsad_region_t region_of(
    input logic [23:0] a,
    input logic [1:0] sz,
    input logic ee4k,
    input logic emap
  );
    logic [23:0] s_end;
    logic [23:0] x_base;
    case (sz)
      2'b00: s_end = dsad_pkg::SRAM_END_4K;
      2'b01: s_end = dsad_pkg::SRAM_END_8K;
      2'b10: s_end = dsad_pkg::SRAM_END_16K;
      default: s_end = dsad_pkg::SRAM_END_32K;
    endcase
    // The largest SRAM leaves a hole up to the next 64K boundary.
    x_base = (sz == 2'b11) ? dsad_pkg::EXT_BASE_32K : s_end + dsad_pkg::ADDR_ONE;
    if (a <= dsad_pkg::IO_END) begin
      region_of = dsad_pkg::RGN_IO;
    end else if (a < dsad_pkg::SRAM_BASE) begin
      // Unmapped EEPROM and the tail after a 2K part both read as holes.
      region_of = (emap && a <= (ee4k ? dsad_pkg::EE_END_4K : dsad_pkg::EE_END_2K)) ?
                  dsad_pkg::RGN_EE : dsad_pkg::RGN_HOLE;
    end else if (a <= s_end) begin
      region_of = dsad_pkg::RGN_SRAM;
    end else if (a >= x_base) begin
      region_of = dsad_pkg::RGN_EXT;
    end else begin
      region_of = dsad_pkg::RGN_HOLE;
    end
  endfunction

  // Page and byte of an EEPROM byte offset, page masked to the part size.
  function automatic logic [11:0] ee_index(input logic [11:0] off, input logic ee4k);
    logic [6:0] page;
    page = 7'(off >> dsad_pkg::EE_PAGE_LSB);
    if (!ee4k) begin
      page = page & dsad_pkg::EE_PAGE_MASK_2K;
    end
    ee_index = {page, off[4:0]};
  endfunction

  // Keep only the selected number of external address lines.
  function automatic logic [23:0] ext_mask(input logic [4:0] bits);
    logic [4:0] b;
    b = bits;
    if (b < dsad_pkg::EXT_BITS_MIN) begin
      b = dsad_pkg::EXT_BITS_MIN;
    end
    if (b > dsad_pkg::EXT_BITS_MAX) begin
      b = dsad_pkg::EXT_BITS_MAX;
    end
    ext_mask = ~(24'hffffff << b);
  endfunction

  // One window matcher per chip select, each with its own settings.
  for (genvar i = 0; i < dsad_pkg::CS_COUNT; i++) begin : g_cs
    dsad_cs_match u_cs (
      .addr(bus_addr),
      .base(cs_base[i]),
      .size(cs_size[i]),
      .kind(cs_type[i]),
      .three_port(three_port),
      .hit(cs_hit[i])
    );
  end

  dsad_cal_loader u_cal (
    .core_clk(core_clk),
    .rst(rst),
    .cal_index(cal_index),
    .cal_load(cal_load),
    .cal_busy(cal_busy)
  );

  // Lowest matching chip select wins; its waits are counted in core cycles.
  always_comb begin
    first_hit = 4'h0;
    hit_wait = 5'h00;
    any_sdram = 1'b0;
    for (int i = dsad_pkg::CS_COUNT - 1; i >= 0; i--) begin
      if (cs_type[i] == dsad_pkg::CS_SDRAM) begin
        any_sdram = 1'b1;
      end
      if (cs_hit[i]) begin
        first_hit = 4'h1 << i;
        // Two doubled-clock ticks per core cycle, rounded up.
        hit_wait = 5'((5'(cs_wait[i]) + 5'(ext_mux_mode) + 5'h01) >> 1);
        if (cs_type[i] == dsad_pkg::CS_SDRAM) begin
          hit_wait = hit_wait + 5'(sdram_cas);
        end
      end
    end
  end

  // Same-cycle region decode so internal accesses finish at the next edge.
  always_comb begin
    take = (st.fsm == dsad_pkg::FSM_IDLE) && !cal_busy && (bus_rd || bus_wr);
    rgn = region_of(bus_addr, sram_size, eeprom_4k, eeprom_mapped);
    hole = (rgn == dsad_pkg::RGN_HOLE) || (rgn == dsad_pkg::RGN_EXT && first_hit == 4'h0);
    ee_split = ee_index(12'(bus_addr - dsad_pkg::EE_BASE), eeprom_4k);
    ee_sep = ee_index(ee_space_addr, eeprom_4k);
  end

  // Next state: access sequencing, index split, refresh and row commands.
  always_comb begin
    next_st = st;
    next_st.bus_done = 1'b0;
    next_st.tgt_we = 1'b0;
    next_st.sdram_refresh_req = 1'b0;
    next_st.nvm_accept = 1'b0;
    next_st.nvm_reject = 1'b0;
    next_st.sig_write_go = 1'b0;
    next_st.sig_erase_go = 1'b0;
    next_st.chip_erase_go = 1'b0;
    case (st.fsm)
      dsad_pkg::FSM_IDLE: begin
        next_st.bus_stall = cal_busy;
        if (take) begin
          next_st.sel_io = (rgn == dsad_pkg::RGN_IO);
          next_st.sel_eeprom = (rgn == dsad_pkg::RGN_EE);
          next_st.sel_sram = (rgn == dsad_pkg::RGN_SRAM);
          next_st.sel_ext = (rgn == dsad_pkg::RGN_EXT) && !hole;
          next_st.sel_hole = hole;
          next_st.cs_sel = (rgn == dsad_pkg::RGN_EXT) ? first_hit : 4'h0;
          next_st.ext_addr = bus_addr & ext_mask(ext_addr_bits);
          next_st.ext_phases = ext_mux_mode;
          next_st.wr_q = bus_wr;
          next_st.rd_q = bus_rd;
          // Short and bit forms outside their reach are refused: region select still set, but no write strobe and a zero read.
          next_st.op_illegal = (short_io_op && bus_addr > dsad_pkg::SHORT_IO_END) ||
                               (bit_access_op && bus_addr > dsad_pkg::BIT_IO_END);
          if (rgn == dsad_pkg::RGN_EE) begin
            next_st.eeprom_page_index = ee_split[11:5];
            next_st.eeprom_byte_index = ee_split[4:0];
          end
          if (next_st.sel_ext && hit_wait != 5'h00) begin
            next_st.fsm = dsad_pkg::FSM_WAIT;
            next_st.wait_cnt = hit_wait;
            next_st.bus_stall = 1'b1;
          end else begin
            // Holes finish at once: no write strobe and a zero read.
            next_st.bus_done = 1'b1;
            next_st.tgt_we = bus_wr && !hole && !next_st.op_illegal;
            next_st.bus_rdata = (hole || !bus_rd || next_st.op_illegal) ? 8'h00 : tgt_rdata;
          end
        end
      end
      dsad_pkg::FSM_WAIT: begin
        if (st.wait_cnt == 5'h01) begin
          next_st.fsm = dsad_pkg::FSM_IDLE;
          next_st.bus_stall = 1'b0;
          next_st.bus_done = 1'b1;
          next_st.tgt_we = st.wr_q && !st.op_illegal;
          next_st.bus_rdata = (st.rd_q && !st.op_illegal) ? tgt_rdata : 8'h00;
        end else begin
          next_st.wait_cnt = st.wait_cnt - 5'h01;
        end
      end
      default: begin
        next_st.fsm = dsad_pkg::FSM_IDLE;
      end
    endcase

    // The separate EEPROM space uses the same page split as the mapped window.
    if (ee_space_req) begin
      next_st.eeprom_page_index = ee_sep[11:5];
      next_st.eeprom_byte_index = ee_space_addr[4:0];
    end

    // Flash pointer: bit 0 picks a byte in the 16-bit word and is dropped.
    if (flash_small) begin
      next_st.flash_word_index = 8'(flash_ptr >> dsad_pkg::FLASH_WORD_LSB) &
                                 dsad_pkg::FLASH_WORD_MASK_SMALL;
      next_st.flash_page_index = 11'(flash_ptr >> dsad_pkg::FLASH_PAGE_LSB_SMALL) &
                                 dsad_pkg::FLASH_PAGE_MASK_SMALL;
    end else begin
      next_st.flash_word_index = 8'(flash_ptr >> dsad_pkg::FLASH_WORD_LSB);
      next_st.flash_page_index = 11'(flash_ptr >> dsad_pkg::FLASH_PAGE_LSB);
    end

    // Refresh tick; a zero period turns refresh off altogether.
    if (sdram_refresh_period != 10'h000) begin
      if (st.ref_cnt >= sdram_refresh_period - 10'h001) begin
        next_st.ref_cnt = 10'h000;
        next_st.sdram_refresh_req = any_sdram;
      end else begin
        next_st.ref_cnt = st.ref_cnt + 10'h001;
      end
    end else begin
      next_st.ref_cnt = 10'h000;
    end

    // Calibration row is read-only; chip erase never touches the signature.
    if (nvm_req) begin
      case (nvm_op)
        dsad_pkg::NVM_CAL_WRITE, dsad_pkg::NVM_CAL_ERASE: next_st.nvm_reject = 1'b1;
        dsad_pkg::NVM_CAL_READ: next_st.nvm_accept = 1'b1;
        dsad_pkg::NVM_SIG_WRITE: begin
          next_st.nvm_accept = 1'b1;
          next_st.sig_write_go = 1'b1;
        end
        dsad_pkg::NVM_SIG_ERASE: begin
          next_st.nvm_accept = 1'b1;
          next_st.sig_erase_go = 1'b1;
        end
        dsad_pkg::NVM_CHIP_ERASE: begin
          next_st.nvm_accept = 1'b1;
          next_st.chip_erase_go = 1'b1;
        end
        default: next_st.nvm_reject = 1'b1;
      endcase
    end
  end

  // Stall starts high so nothing is taken before the calibration copy.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= '0;
      st.bus_stall <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Every output except cal_index and cal_load is a field of the registered state.
  assign sel_io = st.sel_io;
  assign sel_eeprom = st.sel_eeprom;
  assign sel_sram = st.sel_sram;
  assign sel_ext = st.sel_ext;
  assign sel_hole = st.sel_hole;
  assign cs_sel = st.cs_sel;
  assign ext_addr = st.ext_addr;
  assign ext_phases = st.ext_phases;
  assign bus_stall = st.bus_stall;
  assign bus_done = st.bus_done;
  assign tgt_we = st.tgt_we;
  assign bus_rdata = st.bus_rdata;
  assign op_illegal = st.op_illegal;
  assign flash_word_index = st.flash_word_index;
  assign flash_page_index = st.flash_page_index;
  assign eeprom_page_index = st.eeprom_page_index;
  assign eeprom_byte_index = st.eeprom_byte_index;
  assign sdram_refresh_req = st.sdram_refresh_req;
  assign nvm_accept = st.nvm_accept;
  assign nvm_reject = st.nvm_reject;
  assign sig_write_go = st.sig_write_go;
  assign sig_erase_go = st.sig_erase_go;
  assign chip_erase_go = st.chip_erase_go;

  // Checks on the decoder's own outputs.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence seq_take;
    st.fsm == dsad_pkg::FSM_IDLE && !cal_busy && (bus_rd || bus_wr);
  endsequence

  sequence seq_done_now;
    bus_done && !bus_stall;
  endsequence

  chk_io_region: assert property (seq_take ##0 (bus_addr <= dsad_pkg::IO_END)
    |=> sel_io && !sel_hole ##0 seq_done_now)
    else $error("I/O address not routed to I/O");

  chk_sram32_hole: assert property (seq_take ##0 (sram_size == 2'b11 && bus_addr == 24'h00a000)
    |=> sel_hole && cs_sel == 4'h0)
    else $error("Gap after 32K SRAM not reserved");

  chk_hole_zero: assert property (seq_take ##0 (hole && bus_rd && !bus_wr)
    |=> seq_done_now ##0 (bus_rdata == 8'h00 && !tgt_we))
    else $error("Hole access stalled, wrote or read nonzero");

  chk_short_reach: assert property (seq_take ##0 (short_io_op && bus_addr > dsad_pkg::SHORT_IO_END)
    |=> op_illegal && !tgt_we)
    else $error("Short I/O beyond 0x3F not refused");

  chk_bit_reach: assert property (seq_take ##0 (bit_access_op && bus_addr > dsad_pkg::BIT_IO_END)
    |=> op_illegal)
    else $error("Bit access beyond 0x1F not refused");

  chk_wait_end: assert property ($rose(bus_stall) && !cal_busy
    |-> !bus_done ##[1:20] ($fell(bus_stall) && bus_done))
    else $error("Wait states did not end with done");

  chk_cal_locked: assert property (nvm_req && (nvm_op == dsad_pkg::NVM_CAL_WRITE ||
    nvm_op == dsad_pkg::NVM_CAL_ERASE) |=> nvm_reject && !nvm_accept)
    else $error("Calibration row write or erase accepted");

  chk_chip_erase: assert property (nvm_req && nvm_op == dsad_pkg::NVM_CHIP_ERASE
    |=> chip_erase_go && !sig_erase_go)
    else $error("Chip erase touched signature row");

  chk_flash_word: assert property (!flash_small
    |=> flash_word_index == $past(flash_ptr[8:1]))
    else $error("Flash word index wrong");
endmodule
`default_nettype wire

// ===== dsad_tgt_model.sv
// Target side model: read data of I/O, EEPROM, SRAM and external memory.
// Assumes the decoder samples read data only while an access is pending.
`timescale 1ns/100ps
`default_nettype none
module dsad_tgt_model (
  input wire logic [23:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_stall,
  output logic [7:0] tgt_rdata
);
  // Data stands only during an access; otherwise the inverse shows, so stale data never matches.
  always_comb begin
    tgt_rdata = bus_addr[7:0] ^ bus_addr[15:8] ^ bus_addr[23:16];
    if (!(bus_rd || bus_stall)) begin
      tgt_rdata = ~tgt_rdata;
    end
  end
endmodule
`default_nettype wire

// ===== data_space_address_decoder_tb.sv
// Self-checking bench for the data space address decoder.
// Assumes the package, the decoder files and the target model come first.
`timescale 1ns/100ps
`default_nettype none
module data_space_address_decoder_tb;
  logic core_clk, rst, bus_rd, bus_wr, short_io_op, bit_access_op, eeprom_4k, eeprom_mapped, ee_space_req;
  logic three_port, flash_small, nvm_req, sel_io, sel_eeprom, sel_sram, sel_ext, sel_hole, bus_stall, bus_done;
  logic tgt_we, op_illegal, sdram_refresh_req, nvm_accept, nvm_reject, sig_write_go, sig_erase_go, chip_erase_go;
  logic cal_load, wr, map;
  logic [23:0] bus_addr, flash_ptr, ext_addr, a;
  logic [7:0] tgt_rdata, bus_rdata, flash_word_index;
  logic [1:0] sram_size, ext_mux_mode, sdram_cas, ext_phases;
  logic [11:0] ee_space_addr;
  logic [4:0] ext_addr_bits, eeprom_byte_index;
  logic [3:0][1:0] cs_type;
  logic [3:0][23:0] cs_base;
  logic [3:0][4:0] cs_size;
  logic [3:0][3:0] cs_wait;
  logic [9:0] sdram_refresh_period;
  logic [2:0] nvm_op;
  logic [3:0] cs_sel, cal_index;
  logic [10:0] flash_page_index;
  logic [6:0] eeprom_page_index;
  logic [23:0] adr [16] = '{24'h0, 24'hfff, 24'h1000, 24'h17ff, 24'h1800, 24'h1fff, 24'h2000, 24'h2fff,
    24'h3000, 24'h3fff, 24'h5fff, 24'h6000, 24'h9fff, 24'ha000, 24'h10000, 24'h100005};
  int n_fail, samples_checked, seed, n_cal, lat, r;

  dsad_decoder i_dut (.*);
  dsad_tgt_model i_tgt (.*);

  // Free-running core clock, 40 ns period.
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Watchdog: the whole run needs well under this span.
  initial begin
    #(40 * 6000);
    n_fail++;
    end_of_test();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Reference read data, formed the same way the target model forms it.
  function automatic logic [31:0] fx(input logic [23:0] x);
    return {24'h0, x[7:0] ^ x[15:8] ^ x[23:16]};
  endfunction

  // Reference region: 0 I/O, 1 EEPROM, 2 SRAM, 3 external, 4 hole.
  function automatic int region(input int x, input int sz, input int e4, input int mp);
    int send;
    send = (sz == 3) ? 'h9fff : (sz == 2) ? 'h5fff : 'h1fff + (sz + 1) * 'h1000;
    if (x <= 'hfff) return 0;
    if (x < 'h1800 + e4 * 'h800) return mp ? 1 : 4;
    if (x < 'h2000) return 4;
    if (x <= send) return 2;
    if (sz == 3 && x < 'h10000) return 4;
    return 3;
  endfunction

  // One access; the request is held one cycle and dropped at the edge that takes it.
  task automatic access(input logic [23:0] x, input logic w, input logic sh, input logic bt);
    @(posedge core_clk);
    bus_addr <= x;
    bus_rd <= !w;
    bus_wr <= w;
    short_io_op <= sh;
    bit_access_op <= bt;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    bus_wr <= 1'b0;
    short_io_op <= 1'b0;
    bit_access_op <= 1'b0;
    lat = 1;
    #1;
    while (bus_done !== 1'b1 && lat < 20) begin
      @(posedge core_clk);
      #1;
      lat++;
    end
  endtask

  // Main sequence: reset, region map, reach limits, chip select waits, row commands, index split.
  initial begin
    seed = 32'h3dd053b5;
    {rst, bus_rd, bus_wr, short_io_op, bit_access_op, eeprom_4k, eeprom_mapped, ee_space_req} = 8'h80;
    {three_port, flash_small, nvm_req, nvm_op, sram_size, ext_mux_mode, sdram_cas} = 12'h0;
    {bus_addr, flash_ptr, ee_space_addr, sdram_refresh_period} = '0;
    ext_addr_bits = 5'h18;
    cs_type = '1;
    {cs_base, cs_size, cs_wait} = '0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    n_cal = 0;
    do begin
      @(posedge core_clk);
      #1;
      if (cal_load === 1'b1) begin
        chk(cal_index, n_cal);
        n_cal++;
      end
    end while (bus_stall !== 1'b0 && n_cal < 30);
    chk(n_cal, 4);
    for (int sz = 0; sz < 8; sz++) begin
      @(posedge core_clk);
      map = 1'($random(seed));
      sram_size <= sz[1:0];
      eeprom_4k <= sz[2];
      eeprom_mapped <= map;
      for (int k = 0; k < 16; k++) begin
        wr = 1'($random(seed));
        access(adr[k], wr, 1'b0, 1'b0);
        r = region(int'(adr[k]), sz % 4, sz / 4, int'(map));
        chk(lat, 1);
        // Every chip select is off here, so external addresses must land in a hole.
        chk({sel_hole, sel_ext, sel_sram, sel_eeprom, sel_io}, 32'h1 << (r == 3 ? 4 : r));
        if (r == 1) chk({eeprom_page_index, eeprom_byte_index}, adr[k] - 24'h001000);
        chk(bus_rdata, (r >= 3 || wr) ? 32'h0 : fx(adr[k]));
        chk(tgt_we, wr && r < 3);
      end
    end
    for (int k = 0; k < 4; k++) begin
      a = k[0] ? (k[1] ? 24'h40 : 24'h20) : (k[1] ? 24'h3f : 24'h1f);
      access(a, 1'b0, k[1], !k[1]);
      chk(op_illegal, k[0]);
      chk(bus_rdata, k[0] ? 32'h0 : fx(a));
    end
    @(posedge core_clk);
    cs_type[0] <= dsad_pkg::CS_STATIC;
    cs_base[0] <= 24'h100000;
    cs_wait[0] <= 4'h3;
    three_port <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      @(posedge core_clk);
      ext_mux_mode <= m[1:0];
      ext_addr_bits <= m[0] ? 5'h10 : 5'h18;
      access(24'h100005, 1'b0, 1'b0, 1'b0);
      chk(lat, ((4 + m) >> 1) + 1);
      chk(cs_sel, 32'h1);
      chk(bus_rdata, fx(24'h100005));
      chk({ext_phases, ext_addr}, {m[1:0], m[0] ? 24'h000005 : 24'h100005});
      access(24'h100105, 1'b0, 1'b0, 1'b0);
      chk({lat[7:0], bus_rdata}, 32'h100);
    end
    for (int op = 0; op < 8; op++) begin
      @(posedge core_clk);
      nvm_req <= 1'b1;
      nvm_op <= op[2:0];
      @(posedge core_clk);
      nvm_req <= 1'b0;
      #1;
      chk({nvm_accept, nvm_reject, sig_write_go, sig_erase_go, chip_erase_go},
        {op == 0 || (op > 2 && op < 6), op == 1 || op == 2 || op > 5, op == 3, op == 4, op == 5});
    end
    // Dynamic select: CAS latency adds core cycles and refresh pulses once per period.
    @(posedge core_clk);
    cs_type[1] <= dsad_pkg::CS_SDRAM;
    cs_base[1] <= 24'h200000;
    sdram_cas <= 2'h2;
    sdram_refresh_period <= 10'h00a;
    access(24'h200010, 1'b1, 1'b0, 1'b0);
    chk(lat, 5);
    chk(cs_sel, 32'h2);
    chk(tgt_we, 1'b1);
    r = 0;
    repeat (40) begin
      @(posedge core_clk);
      #1;
      r += int'(sdram_refresh_req === 1'b1);
    end
    chk(r, 4);
    // Two ports only: no dynamic select, and static selects stop at 512K.
    @(posedge core_clk);
    three_port <= 1'b0;
    access(24'h200010, 1'b0, 1'b0, 1'b0);
    chk(cs_sel, 32'h0);
    access(24'h100005, 1'b0, 1'b0, 1'b0);
    chk({cs_sel, bus_rdata}, 32'h0);
    for (int k = 0; k < 8; k++) begin
      @(posedge core_clk);
      flash_ptr <= 24'($random(seed));
      flash_small <= k[0];
      ee_space_req <= k[1];
      eeprom_4k <= k[2];
      ee_space_addr <= 12'($random(seed));
      @(posedge core_clk);
      #1;
      chk(flash_word_index, k[0] ? flash_ptr[7:1] : flash_ptr[8:1]);
      chk(flash_page_index, k[0] ? flash_ptr[16:8] : flash_ptr[19:9]);
      if (k[1]) chk({eeprom_page_index, eeprom_byte_index}, ee_space_addr & (k[2] ? 12'hfff : 12'h7ff));
    end
    end_of_test();
  end
endmodule
`default_nettype wire
